// ---- core/stpl_pkg.sv ----
// Shared constants and types for the serial-to-parallel latch
package stpl_pkg;

    // ---------------------------------------------------------------
    // Widths and positions
    // ---------------------------------------------------------------
    localparam int STPL_WIDTH      = 8;
    localparam int STPL_LAST_STAGE = 7;
    localparam int STPL_FIFO_DEPTH = 16;
    localparam int STPL_FIFO_WIDTH = 1;
    localparam int STPL_PEND_W     = 5;

    // ---------------------------------------------------------------
    // Reset and limit values
    // ---------------------------------------------------------------
    localparam logic [STPL_WIDTH-1:0]  STPL_STAGES_RST = 8'h00;
    localparam logic [STPL_WIDTH-1:0]  STPL_EN_N_OFF   = 8'hff;
    localparam logic [STPL_WIDTH-1:0]  STPL_EN_N_ON    = 8'h00;
    localparam logic [STPL_PEND_W-1:0] STPL_PEND_ZERO  = 5'h00;
    localparam logic [STPL_PEND_W-1:0] STPL_PEND_ONE   = 5'h01;
    localparam logic [STPL_PEND_W-1:0] STPL_PEND_MAX   = 5'h1f;

    // ---------------------------------------------------------------
    // Pin levels that cross into the system clock together
    // ---------------------------------------------------------------
    typedef struct packed {
        logic shift;
        logic latch;
        logic oe_n;
        logic ovr;
    } stpl_pins_t;

    localparam stpl_pins_t STPL_PINS_RST = '{shift: 1'b0, latch: 1'b0,
                                             oe_n: 1'b1, ovr: 1'b0};

endpackage

// ---- core/stpl_fifo.sv ----
// Dual-clock FIFO with gray-coded pointers and valid/ready on both sides
`timescale 1ns/10ps
module stpl_fifo
    import stpl_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
)(
    input  wire logic             wr_clk,
    input  wire logic             wr_rst,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_clk,
    input  wire logic             rd_rst,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wbin_q;
    logic [AW:0]      wgray_q;
    logic [AW:0]      rbin_q;
    logic [AW:0]      rgray_q;
    logic [AW:0]      rg_s1_q;
    logic [AW:0]      rg_s2_q;
    logic [AW:0]      wg_s1_q;
    logic [AW:0]      wg_s2_q;
    logic [AW:0]      wbin_d;
    logic [AW:0]      rbin_d;
    logic             push;
    logic             pop;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    // ---------------------------------------------------------------
    // Full and empty from synchronised gray pointers
    // ---------------------------------------------------------------
    // Full compares against the far pointer with its top two bits inverted
    assign wr_ready = wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]};
    assign rd_valid = rgray_q != wg_s2_q;
    assign push     = wr_valid & wr_ready;
    assign pop      = rd_valid & rd_ready;
    assign wbin_d   = wbin_q + {{AW{1'b0}}, 1'b1};
    assign rbin_d   = rbin_q + {{AW{1'b0}}, 1'b1};
    assign rd_data  = mem_q[rbin_q[AW-1:0]];

    // Write side storage and pointer
    always_ff @(posedge wr_clk)
    begin
        if (push)
        begin
            mem_q[wbin_q[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge wr_clk)
    begin
        if (wr_rst)
        begin
            wbin_q  <= '0;
            wgray_q <= '0;
        end
        else if (push)
        begin
            wbin_q  <= wbin_d;
            wgray_q <= to_gray(wbin_d);
        end
    end

    // Read pointer into the write domain, first flop read only by second
    always_ff @(posedge wr_clk)
    begin
        rg_s1_q <= rgray_q;
        rg_s2_q <= rg_s1_q;
    end

    // Read side pointer
    always_ff @(posedge rd_clk)
    begin
        if (rd_rst)
        begin
            rbin_q  <= '0;
            rgray_q <= '0;
        end
        else if (pop)
        begin
            rbin_q  <= rbin_d;
            rgray_q <= to_gray(rbin_d);
        end
    end

    // Write pointer into the read domain
    always_ff @(posedge rd_clk)
    begin
        wg_s1_q <= wgray_q;
        wg_s2_q <= wg_s1_q;
    end

endmodule // stpl_fifo

// ---- core/stpl_core.sv ----
// Serial-to-parallel latch: shift stages, storage register, gated outputs
//
// Overview of operation
// - Eight shift stages, storage register, gated outputs
// - Clear low forces shift stages to zero
// - Shift edge: serial bit into stage zero
// - Latch edge copies all stages into storage
// - Tied clocks: storage lags shift by one
// - Enable low drives storage bits out
// - Enable high floats all parallel outputs
// - Enable never touches shifting or storage
// - Clear leaves storage alone, cascade goes low
// - Latch during clear loads all zeros
// - Cascade output shows the last stage
// - Coincident edges store pre-shift contents
// - Cascade output always driven for chaining
// - Storage holds without a latch edge
`timescale 1ns/10ps
module stpl_core
    import stpl_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  shift_clock,
    input  wire logic                  shift_clear_n,
    input  wire logic                  serial_in,
    input  wire logic                  latch_clock,
    input  wire logic                  output_enable_n,
    output logic      [STPL_WIDTH-1:0] parallel_out,
    output logic      [STPL_WIDTH-1:0] parallel_out_en_n,
    output logic                       cascade_serial_out,
    output logic                       serial_accept,
    output logic                       serial_overrun
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    // Link side
    logic [1:0]                 link_rst_sync_q;
    logic                       link_rst;
    logic                       link_wr_valid;
    logic                       link_wr_ready;
    logic                       link_ovr_tgl_q;
    logic [2:0]                 lrst_sync_q;
    logic                       lrst_lvl_q;
    logic                       lrst_lvl_d;
    logic                       shift_take;

    // Pin synchronisers on the system clock
    stpl_pins_t                 pins_raw;
    stpl_pins_t                 pins_s1_q;
    stpl_pins_t                 pins_s2_q;
    stpl_pins_t                 pins_s3_q;
    stpl_pins_t                 pins_lvl_q;
    stpl_pins_t                 pins_lvl_d;

    // Events
    logic                       shift_rise;
    logic                       latch_rise;
    logic                       ovr_event;

    // Shift pipeline
    logic [STPL_PEND_W-1:0]     pend_q;
    logic [STPL_PEND_W-1:0]     pend_d;
    logic                       fifo_rd_valid;
    logic                       fifo_rd_ready;
    logic [STPL_FIFO_WIDTH-1:0] fifo_rd_data;
    logic                       pop;

    // Registers
    logic [STPL_WIDTH-1:0]      shift_stages_q;
    logic [STPL_WIDTH-1:0]      storage_q;
    logic                       overrun_q;
    logic [STPL_WIDTH-1:0]      en_n_q;

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------
    // Accept a new level only once the second and third flops agree
    function automatic logic settle(input logic s2,
                                    input logic s3,
                                    input logic prev);
        return (s2 == s3) ? s3 : prev;
    endfunction

    // Rising edge of an accepted level
    function automatic logic rose(input logic prev,
                                  input logic next);
        return ~prev & next;
    endfunction

    // ---------------------------------------------------------------
    // Link domain: serial capture on the host's own shift clock
    // ---------------------------------------------------------------
    // System reset carried over to the link clock; the first flop is
    // read only by the second. The link clock may stand still, so the
    // host must toggle it a few times while reset is held.
    always_ff @(posedge shift_clock)
    begin
        link_rst_sync_q <= {link_rst_sync_q[0], srst};
    end

    assign link_rst = link_rst_sync_q[1];

    // Every shift edge out of link reset offers the serial bit sampled at that very edge
    assign link_wr_valid = ~link_rst;

    // A bit that finds the buffer full is lost; flag it by a toggle
    always_ff @(posedge shift_clock)
    begin
        if (link_rst)
        begin
            link_ovr_tgl_q <= 1'b0;
        end
        else if (link_wr_valid && !link_wr_ready)
        begin
            link_ovr_tgl_q <= ~link_ovr_tgl_q;
        end
    end

    // ---------------------------------------------------------------
    // Bit buffer between the link and the system clock
    // ---------------------------------------------------------------
    stpl_fifo #(
        .WIDTH (STPL_FIFO_WIDTH),
        .DEPTH (STPL_FIFO_DEPTH)
    ) u_bit_fifo (
        .wr_clk   (shift_clock),
        .wr_rst   (link_rst),
        .wr_valid (link_wr_valid),
        .wr_ready (link_wr_ready),
        .wr_data  (serial_in),
        .rd_clk   (clk),
        .rd_rst   (srst),
        .rd_valid (fifo_rd_valid),
        .rd_ready (fifo_rd_ready),
        .rd_data  (fifo_rd_data)
    );

    assign serial_accept = link_wr_ready;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    // Clocks and enable are oversampled through equal paths, so two
    // pins tied together produce their edges in the same cycle.
    assign pins_raw = '{shift: shift_clock, latch: latch_clock,
                        oe_n: output_enable_n, ovr: link_ovr_tgl_q};

    always_ff @(posedge clk)
    begin
        pins_s1_q <= pins_raw;
        pins_s2_q <= pins_s1_q;
        pins_s3_q <= pins_s2_q;
    end

    // Accepted levels, filtered per field
    always_comb
    begin
        pins_lvl_d.shift = settle(pins_s2_q.shift, pins_s3_q.shift,
                                  pins_lvl_q.shift);
        pins_lvl_d.latch = settle(pins_s2_q.latch, pins_s3_q.latch,
                                  pins_lvl_q.latch);
        pins_lvl_d.oe_n  = settle(pins_s2_q.oe_n, pins_s3_q.oe_n,
                                  pins_lvl_q.oe_n);
        pins_lvl_d.ovr   = settle(pins_s2_q.ovr, pins_s3_q.ovr,
                                  pins_lvl_q.ovr);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pins_lvl_q <= STPL_PINS_RST;
        end
        else
        begin
            pins_lvl_q <= pins_lvl_d;
        end
    end

    // Link reset level on the system clock, same depth as the pin path
    // so it moves in the cycle that the matching shift edge is seen
    always_ff @(posedge clk)
    begin
        lrst_sync_q <= {lrst_sync_q[1:0], link_rst};
    end

    assign lrst_lvl_d = settle(lrst_sync_q[1], lrst_sync_q[2], lrst_lvl_q);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            lrst_lvl_q <= 1'b1;
        end
        else
        begin
            lrst_lvl_q <= lrst_lvl_d;
        end
    end

    // Edge events
    assign shift_rise = rose(pins_lvl_q.shift, pins_lvl_d.shift);
    assign latch_rise = rose(pins_lvl_q.latch, pins_lvl_d.latch);
    assign ovr_event  = pins_lvl_q.ovr ^ pins_lvl_d.ovr;

    // ---------------------------------------------------------------
    // Pending shifts
    // ---------------------------------------------------------------
    // A detected shift edge is owed one bit from the buffer. The bit
    // normally arrives before the edge is seen; the counter covers the
    // rare case where the pointer crossing is slower.
    // Edges that the link ignored while still leaving reset, and the
    // false edge after reset, are owed no bit; counting them would pop
    // later bits early and break the pre-shift capture of tied clocks.
    assign shift_take    = shift_rise & ~lrst_lvl_q;
    assign fifo_rd_ready = pend_q != STPL_PEND_ZERO;
    assign pop           = fifo_rd_valid & fifo_rd_ready;

    always_comb
    begin
        pend_d = pend_q;
        if (shift_take && !pop && pend_q != STPL_PEND_MAX)
        begin
            pend_d = pend_q + STPL_PEND_ONE;
        end
        else if (!shift_take && pop)
        begin
            pend_d = pend_q - STPL_PEND_ONE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pend_q <= STPL_PEND_ZERO;
        end
        else
        begin
            pend_q <= pend_d;
        end
    end

    // ---------------------------------------------------------------
    // Shift stages
    // ---------------------------------------------------------------
    // The clear acts without the clock and wins over any shift; bits
    // popped while it is low are discarded. The enable plays no part.
    always_ff @(posedge clk or negedge shift_clear_n)
    begin
        if (!shift_clear_n)
        begin
            shift_stages_q <= STPL_STAGES_RST;
        end
        else if (srst)
        begin
            shift_stages_q <= STPL_STAGES_RST;
        end
        else if (pop)
        begin
            // Stage zero takes the bit, every other stage moves up
            shift_stages_q <= {shift_stages_q[STPL_LAST_STAGE-1:0],
                               fifo_rd_data};
        end
    end

    // Last stage drives the chain output at all times
    assign cascade_serial_out = shift_stages_q[STPL_LAST_STAGE];

    // ---------------------------------------------------------------
    // Storage register
    // ---------------------------------------------------------------
    // Loaded only on a latch edge, from the stages as they stand
    // before any shift of the same cycle lands; the clear never
    // reaches it directly, so it holds until the next latch edge.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            storage_q <= STPL_STAGES_RST;
        end
        else if (latch_rise)
        begin
            storage_q <= shift_stages_q;
        end
    end

    assign parallel_out = storage_q;

    // ---------------------------------------------------------------
    // Output enable
    // ---------------------------------------------------------------
    // One enable per pin, low while the pin is driven
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            en_n_q <= STPL_EN_N_OFF;
        end
        else if (pins_lvl_d.oe_n)
        begin
            en_n_q <= STPL_EN_N_OFF;
        end
        else
        begin
            en_n_q <= STPL_EN_N_ON;
        end
    end

    assign parallel_out_en_n = en_n_q;

    // ---------------------------------------------------------------
    // Overrun flag
    // ---------------------------------------------------------------
    // Sticky until system reset; a set in the reset cycle is dropped
    // because the reset branch takes priority over the set.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            overrun_q <= 1'b0;
        end
        else if (ovr_event)
        begin
            overrun_q <= 1'b1;
        end
    end

    assign serial_overrun = overrun_q;

endmodule // stpl_core

// ---- test/stpl_checker.sv ----
// Port-level assertions for the serial-to-parallel latch
`timescale 1ns/10ps
module stpl_checker
    import stpl_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic                  shift_clock,
    input wire logic                  shift_clear_n,
    input wire logic                  serial_in,
    input wire logic                  latch_clock,
    input wire logic                  output_enable_n,
    input wire logic [STPL_WIDTH-1:0] parallel_out,
    input wire logic [STPL_WIDTH-1:0] parallel_out_en_n,
    input wire logic                  cascade_serial_out,
    input wire logic                  serial_accept,
    input wire logic                  serial_overrun
);
    logic       sh_q;
    logic       lt_q;
    logic [3:0] sh_age_q;
    logic [3:0] lt_age_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ---------------------------------------------------------------
    // Edge ages
    // ---------------------------------------------------------------
    // Raw pin edges; a coarse age bound covers the synchroniser delay
    always_ff @(posedge clk)
    begin
        sh_q     <= shift_clock;
        lt_q     <= latch_clock;
        sh_age_q <= (srst || (shift_clock && !sh_q)) ? 4'h0 :
                    sh_age_q + {3'h0, sh_age_q != 4'hf};
        lt_age_q <= (srst || (latch_clock && !lt_q)) ? 4'h0 :
                    lt_age_q + {3'h0, lt_age_q != 4'hf};
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    chk_en_off:
        assert property (output_enable_n [*8] |-> parallel_out_en_n == STPL_EN_N_OFF)
        else $error("outputs driven while disabled");
    chk_en_on:
        assert property (!output_enable_n [*8] |-> parallel_out_en_n == STPL_EN_N_ON)
        else $error("outputs floating while enabled");
    chk_en_same:
        assert property (parallel_out_en_n == STPL_EN_N_OFF || parallel_out_en_n == STPL_EN_N_ON)
        else $error("output enables disagree");
    chk_store_hold:
        assert property ($changed(parallel_out) |-> lt_age_q <= 4'h8)
        else $error("storage changed without latch edge");
    chk_clear_zero:
        assert property (!shift_clear_n [*2] |-> cascade_serial_out == 1'b0)
        else $error("cascade high during clear");
    chk_latch_clear:
        assert property (($rose(latch_clock) && !shift_clear_n) ##1 !shift_clear_n [*7]
                         |-> parallel_out == STPL_STAGES_RST)
        else $error("latch during clear not zero");
    chk_casc_src:
        assert property ($changed(cascade_serial_out) |-> sh_age_q <= 4'h8 || !shift_clear_n)
        else $error("cascade moved without shift edge");
    chk_over_stick:
        assert property (serial_overrun |=> serial_overrun)
        else $error("overrun flag dropped");

    // Main scenarios reached
    cov_latch_clr: cover property ($rose(latch_clock) && !shift_clear_n);
    cov_tied: cover property ($rose(latch_clock) && $rose(shift_clock));
    cov_overrun: cover property ($rose(serial_overrun));
endmodule // stpl_checker

bind stpl_core stpl_checker i_chk (
    .clk(clk), .srst(srst), .shift_clock(shift_clock), .shift_clear_n(shift_clear_n),
    .serial_in(serial_in), .latch_clock(latch_clock), .output_enable_n(output_enable_n),
    .parallel_out(parallel_out), .parallel_out_en_n(parallel_out_en_n),
    .cascade_serial_out(cascade_serial_out), .serial_accept(serial_accept),
    .serial_overrun(serial_overrun)
);

// ---- test/stpl_host.sv ----
// Behavioural host driving the link pins of the latch
`timescale 1ns/10ps
module stpl_host
(
    output logic shift_clock,
    output logic shift_clear_n,
    output logic serial_in,
    output logic latch_clock
);
    logic lck;

    // Free-running host time base; pins only pulse inside the tasks below
    initial
    begin
        lck           = 1'b0;
        shift_clock   = 1'b0;
        shift_clear_n = 1'b0;
        serial_in     = 1'b0;
        latch_clock   = 1'b0;
    end
    always #24 lck = ~lck;

    // ---------------------------------------------------------------
    // Link transfers
    // ---------------------------------------------------------------
    // Data moves with the falling clock so it is stable at each rise
    task automatic send(input logic [7:0] b, input int n, input logic tied);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge lck);
            serial_in   <= b[i];
            shift_clock <= 1'b0;
            latch_clock <= 1'b0;
            @(negedge lck);
            shift_clock <= 1'b1;
            latch_clock <= tied;
        end
        @(posedge lck);
        shift_clock <= 1'b0;
        latch_clock <= 1'b0;
        serial_in   <= ~serial_in; // Released line must not look held
    endtask

    // Latch edge well after the last shift has settled
    task automatic latch();
        repeat (2) @(posedge lck);
        @(negedge lck);
        latch_clock <= 1'b1;
        @(posedge lck);
        latch_clock <= 1'b0;
    endtask

    // Clear pulse, optionally with a latch edge inside it
    task automatic clear(input logic with_latch);
        @(posedge lck);
        shift_clear_n <= 1'b0;
        if (with_latch)
            latch();
        repeat (3) @(posedge lck);
        shift_clear_n <= 1'b1;
    endtask

    // Clear lifted before any real shifting starts
    task automatic release_clear();
        @(posedge lck);
        shift_clear_n <= 1'b1;
    endtask

    // Pulses too short for the synchroniser, so the buffer overfills
    task automatic burst(input int n);
        repeat (n)
        begin
            #4 shift_clock <= 1'b1;
            #4 shift_clock <= 1'b0;
        end
    endtask
endmodule // stpl_host

// ---- test/testbench.sv ----
// Self-checking bench for the serial-to-parallel latch
`timescale 1ns/10ps
module testbench import stpl_pkg::*;;
    logic                  clk, srst, output_enable_n;
    logic                  shift_clock, shift_clear_n, serial_in, latch_clock;
    logic [STPL_WIDTH-1:0] parallel_out, parallel_out_en_n;
    logic                  cascade_serial_out, serial_accept, serial_overrun;
    int                    failures, checks, m_sh, m_st, seed;

    // System clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    stpl_core i_dut (
        .clk(clk), .srst(srst), .shift_clock(shift_clock), .shift_clear_n(shift_clear_n),
        .serial_in(serial_in), .latch_clock(latch_clock), .output_enable_n(output_enable_n),
        .parallel_out(parallel_out), .parallel_out_en_n(parallel_out_en_n),
        .cascade_serial_out(cascade_serial_out), .serial_accept(serial_accept),
        .serial_overrun(serial_overrun)
    );
    stpl_host i_host (.shift_clock(shift_clock), .shift_clear_n(shift_clear_n),
                      .serial_in(serial_in), .latch_clock(latch_clock));

    // ---------------------------------------------------------------
    // Checking and reference model
    // ---------------------------------------------------------------
    task automatic close_out();
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Outputs lag the pins by the synchroniser, so wait it out
    task automatic settle();
        repeat (12) @(posedge clk);
        @(negedge clk);
    endtask

    // Frame through host and reference together, first bit ends highest
    task automatic frame(input logic [7:0] b, input int n, input logic tied);
        for (int i = n - 1; i >= 0; i--)
        begin
            if (tied)
                m_st = m_sh;
            m_sh = ((m_sh << 1) | int'(b[i])) & 255;
        end
        i_host.send(b, n, tied);
        settle();
    endtask

    task automatic store();
        m_st = m_sh;
        i_host.latch();
        settle();
    endtask

    task automatic check_all();
        cmp_byte(parallel_out, m_st[7:0]);
        cmp_bit(cascade_serial_out, m_sh[7]);
    endtask

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial
    begin
        srst = 1'b1;
        output_enable_n = 1'b1;
        failures = 0;
        checks = 0;
        m_sh = 0;
        m_st = 0;
        seed = $urandom(32'hc4ac);
        // Link side needs its own edges to see the reset
        fork
            repeat (5) @(posedge clk);
            i_host.send(8'h00, 4, 1'b0);
        join
        @(posedge clk);
        srst <= 1'b0;
        i_host.send(8'h00, 6, 1'b0);
        settle();
        i_host.release_clear();
        settle();
        check_all();
        cmp_byte(parallel_out_en_n, STPL_EN_N_OFF);
        @(posedge clk);
        output_enable_n <= 1'b0;
        settle();
        cmp_byte(parallel_out_en_n, STPL_EN_N_ON);
        // Random bytes; storage holds until its own edge
        repeat (6)
        begin
            frame(8'($urandom), 8, 1'b0);
            check_all();
            store();
            check_all();
        end
        // Short frame keeps older bits in the upper stages
        frame(8'h05, 3, 1'b0);
        store();
        check_all();
        // Floating outputs while data keeps moving
        @(posedge clk);
        output_enable_n <= 1'b1;
        frame(8'($urandom), 8, 1'b0);
        store();
        cmp_byte(parallel_out_en_n, STPL_EN_N_OFF);
        check_all();
        @(posedge clk);
        output_enable_n <= 1'b0;
        // Shared clocks: storage takes pre-shift stages
        repeat (2)
        begin
            frame(8'($urandom), 8, 1'b1);
            check_all();
        end
        i_host.clear(1'b0);
        m_sh = 0;
        settle();
        check_all();
        frame(8'h06, 3, 1'b0);
        store();
        check_all();
        i_host.clear(1'b1);
        m_sh = 0;
        m_st = 0;
        settle();
        check_all();
        cmp_bit(serial_accept, 1'b1);
        cmp_bit(serial_overrun, 1'b0);
        // Overdriven link: buffer fills, then refuses
        i_host.burst(40);
        settle();
        cmp_bit(serial_accept, 1'b0);
        cmp_bit(serial_overrun, 1'b1);
        close_out();
    end

    // Watchdog, roughly twenty times the expected run
    initial
    begin
        #200000;
        failures++;
        close_out();
    end
endmodule // testbench
